// [rtl/tdbt_engine.sv]
// block transfer engine: apb registers, pixel sequencer, memory and host ports.
// assumes a same-clock display memory answering each request with mem_ack.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
`include "tdbt_params.svh"
`default_nettype none
module tdbt_engine
  import tdbt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output tdbt_mem_type mem,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  output tdbt_host_type host,
  input wire logic host_ready,
  output logic busy
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  tdbt_ctrl_type ctrl; // mode bits
  logic [18:0] src_addr, dst_addr; // byte start addresses
  logic [15:0] off, wid, hgt, rop_sel, bg, fg; // offset, size, colours
  tdbt_state_type state; // sequencer state
  logic [15:0] col, row; // pixel counters
  logic [18:0] src_line, dst_line; // current line start addresses
  logic [15:0] pix_src, pix_dst; // fetched operands
  logic [15:0] hbuf; // host word being packed
  logic hpos, hbyte, hfill; // lane, byte of pixel, partial word held

  // raster operation: code bit {s,d} gives each result bit
  function automatic logic [15:0] rop_apply(input logic [3:0] code,
                                            input logic [15:0] s,
                                            input logic [15:0] d);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      r[i] = code[{s[i], d[i]}];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire [15:0] idx = paddr[17:2];
  wire setup = psel & ~penable;
  wire wr_take = psel & penable & pwrite & pready;
  wire hit = idx == `TDBT_IDX_CTRL || idx == `TDBT_IDX_STAT || idx == `TDBT_IDX_SRC ||
             idx == `TDBT_IDX_DST || idx == `TDBT_IDX_OFF || idx == `TDBT_IDX_ROP ||
             idx == `TDBT_IDX_WID || idx == `TDBT_IDX_HGT || idx == `TDBT_IDX_BG ||
             idx == `TDBT_IDX_FG;
  wire idle = state == S_IDLE;
  wire start = wr_take & ~pslverr & idx == `TDBT_IDX_CTRL & pwdata[`TDBT_START_BIT] & idle;
  logic [31:0] rd_mux;
  always_comb begin
    unique case (idx)
      `TDBT_IDX_CTRL: rd_mux = {22'h0, ctrl};
      `TDBT_IDX_STAT: rd_mux = {row, 15'h0, ~idle};
      `TDBT_IDX_SRC: rd_mux = {13'h0, src_addr};
      `TDBT_IDX_DST: rd_mux = {13'h0, dst_addr};
      `TDBT_IDX_OFF: rd_mux = {16'h0, off};
      `TDBT_IDX_ROP: rd_mux = {28'h0, rop_sel[3:0]};
      `TDBT_IDX_WID: rd_mux = {16'h0, wid};
      `TDBT_IDX_HGT: rd_mux = {16'h0, hgt};
      `TDBT_IDX_BG: rd_mux = {16'h0, bg};
      `TDBT_IDX_FG: rd_mux = {16'h0, fg};
      default: rd_mux = 32'h0;
    endcase
  end

  // zero-wait slave: answer registered in the setup cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~hit;
      prdata <= setup ? rd_mux : 32'h0;
    end
  end

  // register writes; settings are frozen while a transfer runs
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ctrl <= '0;
      {src_addr, dst_addr} <= {`TDBT_RST_ADDR, `TDBT_RST_ADDR};
      {off, wid, hgt} <= {`TDBT_RST16, `TDBT_RST16, `TDBT_RST16};
      {rop_sel, bg, fg} <= {`TDBT_RST16, `TDBT_RST16, `TDBT_RST16};
    end else if (wr_take & idle) begin
      unique case (idx)
        `TDBT_IDX_CTRL: ctrl <= pwdata[`TDBT_CTRL_W-1:0];
        `TDBT_IDX_SRC: src_addr <= pwdata[18:0]; // RQ16
        `TDBT_IDX_DST: dst_addr <= pwdata[18:0]; // RQ16
        `TDBT_IDX_OFF: off <= pwdata[15:0];
        `TDBT_IDX_ROP: rop_sel <= {12'h0, pwdata[3:0]};
        `TDBT_IDX_WID: wid <= pwdata[15:0];
        `TDBT_IDX_HGT: hgt <= pwdata[15:0];
        `TDBT_IDX_BG: bg <= pwdata[15:0];
        `TDBT_IDX_FG: fg <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // datapath decode
  wire op_read = ctrl.op == `TDBT_OP_READ;
  wire op_move = ctrl.op == `TDBT_OP_MOVE;
  wire op_pat = ctrl.op == `TDBT_OP_PAT;
  wire need_src = ctrl.op != `TDBT_OP_SOLID;
  wire do_expand = ctrl.expand & op_move; // RQ5
  wire use_rop = ctrl.rop_en & ~op_read; // RQ2 RQ12 RQ13
  wire do_transp = ctrl.transp & (op_move | op_pat); // RQ6
  wire line_last_pixel = col == wid - 16'h1;
  wire last_row = row == hgt - 16'h1;
  // only 8 and 16 bpp exist: one or two bytes per pixel
  wire [18:0] col_b = ctrl.bpp16 ? {2'b0, col, 1'b0} : {3'b0, col}; // RQ24
  wire [18:0] pat_b = ctrl.bpp16 ? {15'h0, col[2:0], 1'b0} : {16'h0, col[2:0]};
  wire [18:0] src_pix = do_expand ? src_line + {6'h0, col[15:3]} :
                        op_pat ? src_line + pat_b : src_line + col_b; // RQ8
  wire [18:0] dst_pix = dst_line + col_b;
  // pattern rows wrap every eight lines back to the stored block
  wire [18:0] pat_row = ctrl.bpp16 ? {12'h0, row[2:0], 4'h0} : {13'h0, row[2:0], 3'h0};
  // rectangular step is the shared offset in words; linear runs on
  wire [18:0] rect_step = {2'b0, off, 1'b0}; // RQ15
  wire [18:0] lin_step = ctrl.bpp16 ? {2'b0, wid, 1'b0} : {3'b0, wid};
  wire [18:0] next_src_line = op_pat ? src_addr + pat_row + (ctrl.bpp16 ? 19'h10 : 19'h8) :
                              src_line + (ctrl.src_rect ? rect_step : lin_step);
  wire [18:0] next_dst_line = dst_line + (ctrl.dst_rect ? rect_step : lin_step); // RQ20 RQ22
  // pattern row 7 wraps back to the base
  wire [18:0] pat_next = row[2:0] == 3'h7 ? src_addr : next_src_line;
  // byte lane of a memory word
  wire [7:0] rd_byte = mem.addr[0] ? mem_rdata[15:8] : mem_rdata[7:0];
  wire [15:0] rd_pix = ctrl.bpp16 ? mem_rdata : {8'h0, rd_byte};
  wire [15:0] colour_mask = ctrl.bpp16 ? 16'hffff : 16'h00ff;
  wire [15:0] fg_pix = fg & colour_mask; // RQ14
  wire exp_bit = pix_src[~col[2:0]];
  wire [15:0] src_val = ~need_src ? fg_pix :
                        do_expand ? (exp_bit ? fg_pix : bg & colour_mask) : pix_src;
  wire [15:0] result = use_rop ? rop_apply(rop_sel[3:0], src_val, pix_dst) & colour_mask : src_val; // RQ18
  wire suppress = do_transp & (src_val == (bg & colour_mask)); // RQ19
  // next state after a fetch of the source operand
  wire [2:0] after_src = op_read ? S_PACK : use_rop ? S_DST : S_WR;
  tdbt_state_type first_st;
  assign first_st = need_src ? S_SRC : use_rop ? S_DST : S_WR;
  // host packing
  wire [7:0] host_byte = hbyte ? pix_src[15:8] : pix_src[7:0];
  wire last_b = hbyte == ctrl.bpp16;
  wire emit = ~ctrl.host16 | hpos | (last_b & line_last_pixel & ctrl.dst_rect); // RQ21 RQ23
  wire [15:0] next_hbuf = hpos ? {host_byte, hbuf[7:0]} : {hbuf[15:8], host_byte};

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: one pixel at a time, memory request held until ack
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state <= S_IDLE;
      {col, row} <= 32'h0;
      {src_line, dst_line} <= {`TDBT_RST_ADDR, `TDBT_RST_ADDR};
      {pix_src, pix_dst, hbuf} <= 48'h0;
      {hpos, hbyte, hfill} <= 3'h0;
      mem <= '0;
      host <= '0;
      busy <= 1'b0;
    end else begin
      unique case (state)
        S_IDLE: if (start) begin
          // corner pixel of each window comes first
          src_line <= src_addr; // RQ7
          dst_line <= dst_addr; // RQ7
          {col, row} <= 32'h0;
          {hbyte, hfill} <= 2'h0;
          hpos <= pwdata[8] & pwdata[9]; // RQ3
          busy <= 1'b1;
          state <= pwdata[1:0] != `TDBT_OP_SOLID ? S_SRC :
                   pwdata[5] ? S_DST : S_WR;
        end
        S_SRC: if (!mem.req) begin
          mem <= '{req: 1'b1, we: 1'b0, addr: src_pix, wdata: 16'h0, be: 2'b11}; // RQ1 RQ4
        end else if (mem_ack) begin
          mem.req <= 1'b0;
          pix_src <= do_expand ? {8'h0, rd_byte} : rd_pix;
          state <= tdbt_state_type'(after_src);
        end
        S_DST: if (!mem.req) begin
          mem <= '{req: 1'b1, we: 1'b0, addr: dst_pix, wdata: 16'h0, be: 2'b11}; // RQ17
        end else if (mem_ack) begin
          mem.req <= 1'b0;
          pix_dst <= rd_pix;
          state <= S_WR;
        end
        S_WR: if (suppress) begin
          state <= S_ADV;
        end else if (!mem.req) begin
          // result goes to the destination pixel, the one just read when use_rop is set
          mem.req <= 1'b1; // RQ17
          mem.we <= 1'b1;
          mem.addr <= dst_pix;
          mem.wdata <= ctrl.bpp16 ? result : {result[7:0], result[7:0]}; // RQ13
          mem.be <= ctrl.bpp16 ? 2'b11 : (dst_pix[0] ? 2'b10 : 2'b01);
        end else if (mem_ack) begin
          mem.req <= 1'b0;
          mem.we <= 1'b0;
          state <= S_ADV;
        end
        S_PACK: begin
          // raw memory bytes only, no data function
          hbuf <= next_hbuf; // RQ2
          hfill <= ~emit;
          hpos <= ~emit & ~hpos;
          if (emit) begin
            host <= '{valid: 1'b1, data: next_hbuf};
            state <= S_OUT;
          end else begin
            hbyte <= ~last_b;
            state <= last_b ? S_ADV : S_PACK;
          end
        end
        S_OUT: if (host_ready) begin
          host.valid <= 1'b0;
          hbyte <= ~last_b;
          state <= last_b ? S_ADV : S_PACK;
        end
        S_ADV: begin
          hbyte <= 1'b0;
          if (!line_last_pixel) begin
            col <= col + 16'h1;
            state <= first_st;
          end else begin
            col <= 16'h0;
            row <= row + 16'h1;
            src_line <= op_pat ? pat_next : next_src_line; // RQ8
            dst_line <= next_dst_line; // RQ20 RQ22
            // a rectangular host line restarts at the chosen lane
            if (op_read & ctrl.dst_rect & ctrl.host16) begin
              hpos <= ctrl.phase; // RQ3
            end
            if (last_row) begin
              if (hfill) begin
                host <= '{valid: 1'b1, data: hbuf};
                state <= S_FLUSH;
              end else begin
                busy <= 1'b0;
                state <= S_IDLE;
              end
            end else begin
              state <= first_st; // RQ11
            end
          end
        end
        S_FLUSH: if (host_ready) begin
          host.valid <= 1'b0;
          hfill <= 1'b0;
          busy <= 1'b0;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  read_no_write_a: assert property (busy && op_read |-> !mem.we) // RQ2
    else $error("write issued during read to host");
  // the fetch is launched one edge after start and seen two edges later
  start_corner_a: assert property (start && pwdata[1:0] == `TDBT_OP_MOVE |=> ##2 mem.addr == $past(src_addr, 3)) // RQ7
    else $error("first fetch not at source corner");
  fg_byte_a: assert property (state == S_WR && mem.we && !ctrl.bpp16 && !use_rop && ctrl.op == `TDBT_OP_SOLID
                              |-> mem.wdata == {fg[7:0], fg[7:0]}) // RQ14
    else $error("solid fill byte is not foreground");
  transp_skip_a: assert property (state == S_WR && suppress |=> state == S_ADV && !mem.req) // RQ19
    else $error("background pixel written");
  sequence dst_fetch_s;
    state == S_DST && mem_ack;
  endsequence
  rop_order_a: assert property (dst_fetch_s |=> ##1 (mem.we && mem.addr == $past(mem.addr, 2)) or suppress) // RQ17
    else $error("operation result not at destination read address");
  rect_step_a: assert property (state == S_ADV && line_last_pixel && ctrl.dst_rect
                                |=> dst_line == $past(dst_line) + {2'b0, $past(off), 1'b0}) // RQ22
    else $error("rectangular line step wrong");
  lin_step_a: assert property (state == S_ADV && line_last_pixel && !ctrl.dst_rect && !ctrl.bpp16
                               |=> dst_line == $past(dst_line) + {3'b0, wid}) // RQ20
    else $error("linear line step wrong");
  pat_wrap_a: assert property (op_pat && state == S_SRC && mem.req |-> mem.addr - src_line < 19'h10) // RQ8
    else $error("pattern fetch outside pattern line");
  host_line_a: assert property (op_read && state == S_PACK && last_b && line_last_pixel && ctrl.dst_rect
                                |=> host.valid) // RQ23
    else $error("rectangular host line not closed");
  apb_ans_a: assert property (setup |=> pready ##1 !pready) // RQ16
    else $error("apb answer timing");
endmodule
`default_nettype wire

// [include/tdbt_params.svh]
// constants of the two-dimensional block transfer engine: register indices,
// field positions, reset values. assumes an apb slave with 32-bit data.
//
// Function
// RQ1 - read to host, any layout each side
// RQ2 - read to host ignores data functions
// RQ3 - read phase picks first host byte
// RQ4 - move copies source area to destination
// RQ5 - move may colour-expand source data
// RQ6 - move may apply transparency
// RQ7 - start address is upper-left pixel
// RQ8 - pattern fill repeats stored 8x8 pattern
// RQ9 - software: pattern linear, destination rectangular
// RQ10 - software: pattern starts 16-bit aligned
// RQ11 - fill window from 1x1 to width x height
// RQ12 - pattern fill may use raster operation
// RQ13 - solid fill writes foreground, optional operation
// RQ14 - foreground low byte or full word
// RQ15 - shared line offset in 16-bit words
// RQ16 - byte start addresses, pixel sizes
// RQ17 - raster operation reads then rewrites destination
// RQ18 - four-bit code selects boolean function
// RQ19 - transparency skips background coloured pixels
// RQ20 - linear lines follow on, offset ignored
// RQ21 - linear host lines share a word
// RQ22 - rectangular line adds line offset
// RQ23 - rectangular host lines start new word
// RQ24 - 8 and 16 bpp only
`ifndef TDBT_PARAMS_SVH
`define TDBT_PARAMS_SVH
// register indices; byte address is four times the index
`define TDBT_IDX_CTRL 16'h8000
`define TDBT_IDX_STAT 16'h8002
`define TDBT_IDX_SRC 16'h8004
`define TDBT_IDX_DST 16'h8006
`define TDBT_IDX_OFF 16'h8008
`define TDBT_IDX_ROP 16'h800a
`define TDBT_IDX_WID 16'h800c
`define TDBT_IDX_HGT 16'h800e
`define TDBT_IDX_BG 16'h8010
`define TDBT_IDX_FG 16'h8024
// control fields: op[1:0], then flags, start is write-only
`define TDBT_START_BIT 15
`define TDBT_CTRL_W 10
// operation codes
`define TDBT_OP_READ 2'h0
`define TDBT_OP_MOVE 2'h1
`define TDBT_OP_PAT 2'h2
`define TDBT_OP_SOLID 2'h3
// reset values
`define TDBT_RST16 16'h0000
`define TDBT_RST_ADDR 19'h00000
`endif

// [include/tdbt_pkg.sv]
// types of the block transfer engine: states and carrier structs.
// assumes tdbt_params.svh for the numeric constants.
package tdbt_pkg;
  // sequencer states
  typedef enum logic [2:0] {
    S_IDLE, S_SRC, S_DST, S_WR, S_PACK, S_OUT, S_ADV, S_FLUSH
  } tdbt_state_type;
  // control register layout, msb first
  typedef struct packed {
    logic host16; // 16-bit host data path
    logic phase; // starting host byte lane
    logic expand; // colour expansion in move
    logic transp; // transparency enable
    logic rop_en; // raster operation enable
    logic bpp16; // 16 bits per pixel
    logic dst_rect; // destination rectangular
    logic src_rect; // source rectangular
    logic [1:0] op; // operation
  } tdbt_ctrl_type;
  // display memory request
  typedef struct packed {
    logic req;
    logic we;
    logic [18:0] addr;
    logic [15:0] wdata;
    logic [1:0] be;
  } tdbt_mem_type;
  // host read data word
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } tdbt_host_type;
endpackage

// [tb/tdbt_mem_model.sv]
// display memory partner: 4096 words, one ack for each engine request.
// assumes request fields are held until mem_ack and one request at a time.
`timescale 1ns/10ps
`default_nettype none
module tdbt_mem_model
  import tdbt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire tdbt_mem_type mem,
  input wire logic slow,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [15:0] ram [0:4095]; // word store, preset by the bench
  logic [1:0] dly; // wait states spent on this request
  wire [11:0] widx = mem.addr[12:1]; // word index of the byte address
  ////////////////////////////////////////////////////////////////////////
  // slow mode adds three wait states so the engine must hold its request
  always @(posedge ref_clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata; // old read data must not look valid later
    if (!rst_b) begin
      dly <= 2'h0;
      mem_rdata <= 16'h5a5a;
    end else if (mem.req && !mem_ack) begin
      if (!slow || dly == 2'h3) begin
        mem_ack <= 1'b1;
        dly <= 2'h0;
        if (!mem.we) mem_rdata <= ram[widx];
        if (mem.we && mem.be[0]) ram[widx][7:0] <= mem.wdata[7:0];
        if (mem.we && mem.be[1]) ram[widx][15:8] <= mem.wdata[15:8];
      end else begin
        dly <= dly + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/tdbt_engine_tb.sv]
// self-checking bench of the block transfer engine over apb.
// assumes the memory partner model and a host sink that stalls on demand.
`timescale 1ns/10ps
`include "tdbt_params.svh"
`default_nettype none
module tdbt_engine_tb
  import tdbt_pkg::*;
;
  logic ref_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic host_ready = 0, slow = 0, stall = 0, err_b;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, mem_ack, busy;
  logic [15:0] mem_rdata;
  logic [15:0] hq [$]; // words taken by the host
  tdbt_mem_type mem;
  tdbt_host_type host;
  int err_count = 0, n_compared = 0;
  tdbt_engine DUT (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .host(host), .host_ready(host_ready), .busy(busy));
  tdbt_mem_model u_mem (.ref_clk(ref_clk), .rst_b(rst_b), .mem(mem), .slow(slow),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  // host sink: ready toggles while stalling, so words wait on the sink
  always @(posedge ref_clk) begin
    host_ready <= !stall || !host_ready;
    if (host.valid && host_ready) hq.push_back(host.data);
  end
  ////////////////////////////////////////////////////////////////////////
  // preset byte of each address, unique in its low byte
  function automatic logic [7:0] pre(input logic [18:0] a);
    return a[7:0] ^ 8'h5c;
  endfunction
  function automatic logic [7:0] mb(input logic [18:0] a);
    return u_mem.ram[a[12:1]][a[0]*8 +: 8];
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one apb transfer; the leading edge keeps back-to-back calls race free
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      chk("pready", 1, 0);
      conclude;
    end
    rd = prdata;
    err_b = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_idle;
    int i;
    repeat (2) @(posedge ref_clk);
    chk("busy", 1, busy);
    for (i = 0; i < 5000 && busy !== 1'b0; i++) @(posedge ref_clk);
    if (i == 5000) begin
      chk("busy end", 0, busy);
      conclude;
    end
  endtask
  task automatic cfg(input logic [18:0] s, d, input logic [15:0] o, w, h);
    apb(1, `TDBT_IDX_SRC, s);
    apb(1, `TDBT_IDX_DST, d);
    apb(1, `TDBT_IDX_OFF, o);
    apb(1, `TDBT_IDX_WID, w);
    apb(1, `TDBT_IDX_HGT, h);
  endtask
  task automatic run(input logic [15:0] c);
    apb(1, `TDBT_IDX_CTRL, {16'h0, c | 16'h8000});
    wait_idle;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    apb(0, `TDBT_IDX_FG, 0);
    chk("fg reset", 0, rd);
    apb(0, `TDBT_IDX_ROP, 0);
    chk("rop reset", 0, rd);
    apb(1, `TDBT_IDX_FG, 32'h12a5);
    apb(0, `TDBT_IDX_FG, 0);
    chk("fg", 32'h12a5, rd);
    apb(0, 16'h8001, 0);
    chk("unmapped err", 1, err_b);
    chk("unmapped data", 0, rd);
    $display("test regs done");
  endtask
  // odd start, rectangular 8 bpp, then linear 16 bpp with offset ignored
  task automatic t_solid;
    logic [18:0] a;
    cfg(0, 19'h101, 16'h4, 16'h3, 16'h2);
    run(16'h000b);
    for (a = 19'h100; a < 19'h110; a++) begin
      chk("solid8", (a % 8 >= 1 && a % 8 <= 3) ? 8'ha5 : pre(a), mb(a));
    end
    cfg(0, 19'h200, 16'h4, 16'h3, 16'h2);
    run(16'h0013);
    for (a = 19'h200; a < 19'h210; a++) begin
      chk("solid16", a < 19'h20c ? (a[0] ? 8'h12 : 8'ha5) : pre(a), mb(a));
    end
    $display("test solid done");
  endtask
  // every raster code on a 1x1 window, with a slow memory
  task automatic t_rop;
    logic [4:0] c;
    logic [7:0] e;
    logic [7:0] dd;
    slow <= 1'b1;
    for (c = 0; c < 16; c++) begin
      dd = pre(19'h300 + c);
      for (int j = 0; j < 8; j++) e[j] = c[{1'(8'ha5 >> j), dd[j]}];
      apb(1, `TDBT_IDX_ROP, {28'h0, c[3:0]});
      cfg(0, 19'h300 + c, 16'h0, 16'h1, 16'h1);
      run(16'h0023);
      chk("rop", e, mb(19'h300 + c));
    end
    slow <= 1'b0;
    $display("test rop done");
  endtask
  task automatic t_move;
    logic [7:0] s;
    logic [7:0] bg;
    bg = pre(19'h402);
    apb(1, `TDBT_IDX_BG, {24'h0, bg});
    cfg(19'h400, 19'h500, 16'h4, 16'h3, 16'h2);
    run(16'h0049);
    for (int r = 0; r < 2; r++) begin
      for (int c = 0; c < 3; c++) begin
        s = pre(19'(19'h400 + 3 * r + c));
        chk("move", s == bg ? pre(19'(19'h500 + 8 * r + c)) : s, mb(19'(19'h500 + 8 * r + c)));
      end
    end
    cfg(19'h600, 19'h700, 16'h0, 16'h8, 16'h1);
    run(16'h0081);
    s = pre(19'h600);
    for (int c = 0; c < 8; c++) chk("expand", s[7 - c] ? 8'ha5 : bg, mb(19'(19'h700 + c)));
    $display("test move done");
  endtask
  // pattern wider and taller than 8, with a refused write while busy
  task automatic t_pat;
    cfg(19'h800, 19'h900, 16'h8, 16'ha, 16'h9);
    apb(1, `TDBT_IDX_CTRL, 32'h800a);
    apb(1, `TDBT_IDX_FG, 0);
    apb(0, `TDBT_IDX_STAT, 0);
    chk("stat busy", 1, rd[0]);
    wait_idle;
    apb(0, `TDBT_IDX_FG, 0);
    chk("fg held", 32'h12a5, rd);
    apb(0, `TDBT_IDX_STAT, 0);
    chk("stat idle", 0, rd[0]);
    for (int r = 0; r < 9; r++) begin
      for (int c = 0; c < 10; c++) begin
        chk("pattern", pre(19'(19'h800 + (r % 8) * 8 + c % 8)), mb(19'(19'h900 + 16 * r + c)));
      end
    end
    $display("test pattern done");
  endtask
  task automatic t_read;
    stall <= 1'b1;
    hq.delete();
    cfg(19'ha00, 0, 16'h4, 16'h3, 16'h2);
    run(16'h02e0);
    chk("lin count", 3, hq.size());
    for (int i = 0; i < 3; i++) chk("lin", {pre(19'(19'ha01 + 2 * i)), pre(19'(19'ha00 + 2 * i))}, hq[i]);
    hq.delete();
    run(16'h030c);
    chk("rect count", 4, hq.size());
    chk("rect0", pre(19'ha00), hq[0][15:8]);
    chk("rect1", {pre(19'ha02), pre(19'ha01)}, hq[1]);
    chk("rect2", pre(19'ha08), hq[2][15:8]);
    chk("rect3", {pre(19'ha0a), pre(19'ha09)}, hq[3]);
    hq.delete();
    cfg(19'ha00, 0, 16'h0, 16'h1, 16'h1);
    run(16'h0010);
    chk("h8 count", 2, hq.size());
    chk("h8 lo", pre(19'ha00), hq[0][7:0]);
    chk("h8 hi", pre(19'ha01), hq[1][7:0]);
    stall <= 1'b0;
    $display("test read done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 4096; i++) u_mem.ram[i] = {pre(19'(2 * i + 1)), pre(19'(2 * i))};
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_regs;
    t_solid;
    t_rop;
    t_move;
    t_pat;
    t_read;
    conclude;
  end
  // hang guard, far above the longest expected run
  initial begin
    #400000;
    err_count++;
    conclude;
  end
endmodule
`default_nettype wire
